// ==== verilog/wgc_pkg.sv ====
// Purpose : Shared constants and types for the waveform generator control block.
// Assumes : APB slave with 32-bit data, one aligned word per register.
// Notes   : Converter codes are 12 bits; the offset carries a separate sign.

package wgc_pkg;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam int          WGC_ADDR_W      = 12;
    localparam logic [11:0] WGC_ADDR_CMDA   = 12'h000;
    localparam logic [11:0] WGC_ADDR_CMDB   = 12'h004;
    localparam logic [11:0] WGC_ADDR_STROBE = 12'h008;
    localparam logic [11:0] WGC_ADDR_STATUS = 12'h00c;

    // ****************************************************************
    // Command byte layout
    // ****************************************************************
    localparam int          WGC_CODE_W    = 12;
    localparam int          WGC_SEL_MSB   = 7;
    localparam int          WGC_SEL_LSB   = 5;
    localparam int          WGC_SIGN_BIT  = 4;
    localparam int          WGC_NIB_MSB   = 3;
    localparam int          WGC_SYNC_BIT  = 3;
    localparam int          WGC_EN_BIT    = 2;
    localparam int          WGC_GROUP_BIT = 3;
    localparam logic [2:0]  WGC_SEL_RAMP_DN = 3'h7;
    localparam logic [2:0]  WGC_SEL_RAMP_UP = 3'h6;
    localparam logic [2:0]  WGC_SEL_OFFSET  = 3'h5;
    localparam logic [2:0]  WGC_SEL_AMP     = 3'h4;
    localparam logic [2:0]  WGC_SEL_RANGE   = 3'h1;
    localparam logic [2:0]  WGC_SEL_CTRL    = 3'h0;
    localparam logic [2:0]  WGC_RANGE_MAX   = 3'h5;

    // ****************************************************************
    // Reset and full-scale values
    // ****************************************************************
    localparam logic [11:0] WGC_RST_CODE  = 12'h000;
    localparam logic [11:0] WGC_FULL_CODE = 12'hfff;
    localparam logic [2:0]  WGC_RST_RANGE = 3'h0;

    // Waveform selection encodings.
    typedef enum logic [1:0] {
        WGC_WAVE_DC     = 2'h0,
        WGC_WAVE_SINE   = 2'h1,
        WGC_WAVE_TRI    = 2'h2,
        WGC_WAVE_SQUARE = 2'h3
    } wgc_wave_t;

    // Codes presented to the converters.
    typedef struct packed {
        logic [11:0] ramp_dn;
        logic [11:0] ramp_up;
        logic [11:0] amp;
        logic [11:0] offset;
        logic        offset_sign;
    } wgc_codes_t;

endpackage

// ==== verilog/wgc_code_stage.sv ====
// Purpose : Double-buffered converter code with optional group update.
// Assumes : Load and strobe are single-cycle pulses in the clk_i domain.
// Notes   : A load and a strobe in the same cycle commit the new value.

`timescale 1ns/100ps

module wgc_code_stage #(
    parameter int W = 12
) (
    // Clock and reset.
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Load side.
    input  wire logic         load_i,
    input  wire logic [W-1:0] value_i,
    input  wire logic         group_i,
    input  wire logic         strobe_i,
    // Converter side.
    output logic      [W-1:0] active_o,
    output logic              pending_o
);

    logic [W-1:0] hold_q;

    // Holding register keeps the last written value.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hold_q <= '0;
        end else if (load_i) begin
            hold_q <= value_i;
        end
    end

    // Active register feeds the converter at once or on the group strobe.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            active_o <= '0;
        end else if (load_i && (!group_i || strobe_i)) begin
            active_o <= value_i;
        end else if (strobe_i && group_i) begin
            active_o <= hold_q;
        end
    end

    // Pending shows a value held back waiting for the strobe; clear wins.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pending_o <= 1'b0;
        end else if (load_i) begin
            pending_o <= group_i && !strobe_i;
        end else if (strobe_i) begin
            pending_o <= 1'b0;
        end
    end

endmodule

// ==== verilog/wgc_top.sv ====
// Purpose : Write-only control of a single-channel function generator.
// Assumes : APB slave on clk_i; cycle_end_i pulses at each lowest point.
// Notes   : Analog generation is outside; this block drives codes and gates.

`timescale 1ns/100ps

// Contract
// - Both ramp codes at 4095 give the range full-scale frequency.
// - Duty follows the ratio of ramp codes; equal codes give 50 percent.
// - Disabled with amplitude and offset loaded, output sits at lowest level.
// - Setting enable starts the waveform from its lowest point.
// - Without synchronous halt, clearing enable stops at once, lowest point.
// - With synchronous halt, clearing enable finishes the current cycle first.
// - Synchronous halt applies to sine and triangle only, not square.
// - With group update, new codes wait for the global strobe.
// - Without group update, new codes take effect when written.
// - DC mode: level from offset and sign only; ramps and amplitude ignored.
// - DC mode: level appears only once enable is set.
// - First byte top three bits select the target register.
// - Register 0: halt bit 3, enable bit 2, waveform bits 1 to 0.
// - Waveform codes: 0 DC, 1 sine, 2 triangle, 3 square.
// - Range codes 0 to 5 select 200kHz down to 2Hz.
module wgc_top
    import wgc_pkg::*;
(
    // Clock and reset.
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // APB slave.
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [WGC_ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]           pwdata_i,
    output logic      [31:0]           prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    // Oscillator feedback.
    input  wire logic                  cycle_end_i,
    // Converter and generator controls.
    output wgc_codes_t                 codes_o,
    output logic      [2:0]            range_code_o,
    output wgc_wave_t                  waveform_choice_o,
    output logic                       wave_run_o,
    output logic                       park_low_o,
    output logic                       dc_drive_o
);

    // ****************************************************************
    // State and declarations
    // ****************************************************************
    typedef enum logic [1:0] {
        WGC_ST_IDLE,
        WGC_ST_RUN,
        WGC_ST_DRAIN
    } wgc_state_t;

    wgc_state_t  st_q;
    logic        enable_q;
    logic        sync_halt_q;
    logic        group_update_flag_q;
    logic        cmda_valid_q;
    logic [2:0]  sel_q;
    logic [3:0]  nib_q;
    logic        sign_q;
    logic        acc;
    logic        wr_cmda;
    logic        wr_cmdb;
    logic        strobe;
    logic [7:0]  wbyte;
    logic [11:0] wcode;
    logic        ld_dn;
    logic        ld_up;
    logic        ld_off;
    logic        ld_amp;
    logic        wr_ctrl;
    logic        new_en;
    logic        halt_ok;
    logic [11:0] dn_act;
    logic [11:0] up_act;
    logic [11:0] amp_act;
    logic [12:0] off_act;
    logic [3:0]  pend;

    // Joins the held high nibble and the second byte into a 12-bit code.
    function automatic logic [11:0] wgc_join(input logic [3:0] hi, input logic [7:0] lo);
        return {hi, lo};
    endfunction

    // ****************************************************************
    // APB decode
    // ****************************************************************
    // A transfer completes on the edge where pready is high.
    assign acc     = psel_i && penable_i && pready_o;
    assign wr_cmda = acc && pwrite_i && (paddr_i == WGC_ADDR_CMDA);
    assign wr_cmdb = acc && pwrite_i && (paddr_i == WGC_ADDR_CMDB);
    assign strobe  = acc && pwrite_i && (paddr_i == WGC_ADDR_STROBE);
    assign wbyte   = pwdata_i[7:0];
    assign wcode   = wgc_join(nib_q, wbyte);
    assign wr_ctrl = wr_cmda && (wbyte[WGC_SEL_MSB:WGC_SEL_LSB] == WGC_SEL_CTRL);
    assign new_en  = wbyte[WGC_EN_BIT];
    // Second byte lands only in the register the first byte picked.
    assign ld_dn   = wr_cmdb && cmda_valid_q && (sel_q == WGC_SEL_RAMP_DN);
    assign ld_up   = wr_cmdb && cmda_valid_q && (sel_q == WGC_SEL_RAMP_UP);
    assign ld_off  = wr_cmdb && cmda_valid_q && (sel_q == WGC_SEL_OFFSET);
    assign ld_amp  = wr_cmdb && cmda_valid_q && (sel_q == WGC_SEL_AMP);

    // One wait state: pready rises in the second access cycle.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
        end else begin
            pready_o <= psel_i && penable_i && !pready_o;
        end
    end

    // Read data and error; command ports read as zero, unmapped errors.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else if (psel_i && penable_i && !pready_o) begin
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
            if (paddr_i == WGC_ADDR_STATUS) begin
                if (!pwrite_i) begin
                    prdata_o <= {20'h00000, cmda_valid_q, |pend,
                                 st_q == WGC_ST_DRAIN, wave_run_o,
                                 group_update_flag_q, range_code_o,
                                 waveform_choice_o, sync_halt_q, enable_q};
                end else begin
                    pslverr_o <= 1'b1;
                end
            end else if (paddr_i == WGC_ADDR_CMDA) begin
                pslverr_o <= 1'b0;
            end else if (paddr_i == WGC_ADDR_CMDB) begin
                pslverr_o <= 1'b0;
            end else if (paddr_i == WGC_ADDR_STROBE) begin
                pslverr_o <= 1'b0;
            end else begin
                pslverr_o <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // First-byte latch
    // ****************************************************************
    // The high nibble waits here; a lone first byte changes no code.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_q        <= WGC_SEL_CTRL;
            nib_q        <= 4'h0;
            sign_q       <= 1'b0;
            cmda_valid_q <= 1'b0;
        end else if (wr_cmda) begin
            sel_q        <= wbyte[WGC_SEL_MSB:WGC_SEL_LSB];
            nib_q        <= wbyte[WGC_NIB_MSB:0];
            sign_q       <= wbyte[WGC_SIGN_BIT];
            cmda_valid_q <= wbyte[WGC_SEL_MSB];
        end else if (wr_cmdb) begin
            cmda_valid_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Range and group update
    // ****************************************************************
    // Out-of-table range codes are dropped so the capacitor select stays legal.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            range_code_o        <= WGC_RST_RANGE;
            group_update_flag_q <= 1'b0;
        end else if (wr_cmda && (wbyte[WGC_SEL_MSB:WGC_SEL_LSB] == WGC_SEL_RANGE)) begin
            group_update_flag_q <= wbyte[WGC_GROUP_BIT];
            if (wbyte[2:0] <= WGC_RANGE_MAX) begin
                range_code_o <= wbyte[2:0];
            end
        end
    end

    // ****************************************************************
    // Control register
    // ****************************************************************
    // Enable, halt mode and waveform apply on the first byte alone.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            enable_q          <= 1'b0;
            sync_halt_q       <= 1'b0;
            waveform_choice_o <= WGC_WAVE_DC;
        end else if (wr_ctrl) begin
            enable_q          <= new_en;
            sync_halt_q       <= wbyte[WGC_SYNC_BIT];
            waveform_choice_o <= wgc_wave_t'(wbyte[1:0]);
        end
    end

    // ****************************************************************
    // Converter codes
    // ****************************************************************
    wgc_code_stage #(.W(12)) u_dn (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .load_i    (ld_dn),
        .value_i   (wcode),
        .group_i   (group_update_flag_q),
        .strobe_i  (strobe),
        .active_o  (dn_act),
        .pending_o (pend[0])
    );

    wgc_code_stage #(.W(12)) u_up (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .load_i    (ld_up),
        .value_i   (wcode),
        .group_i   (group_update_flag_q),
        .strobe_i  (strobe),
        .active_o  (up_act),
        .pending_o (pend[1])
    );

    wgc_code_stage #(.W(13)) u_off (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .load_i    (ld_off),
        .value_i   ({sign_q, wcode}),
        .group_i   (group_update_flag_q),
        .strobe_i  (strobe),
        .active_o  (off_act),
        .pending_o (pend[2])
    );

    wgc_code_stage #(.W(12)) u_amp (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .load_i    (ld_amp),
        .value_i   (wcode),
        .group_i   (group_update_flag_q),
        .strobe_i  (strobe),
        .active_o  (amp_act),
        .pending_o (pend[3])
    );

    // Codes go out unaltered, so full-scale and ratio follow the analog part.
    // DC mode zeroes ramps and amplitude; offset codes pass regardless of
    // enable, so a disabled output still parks at its lowest level.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            codes_o <= '0;
        end else begin
            codes_o.offset      <= off_act[11:0];
            codes_o.offset_sign <= off_act[12];
            if (waveform_choice_o == WGC_WAVE_DC) begin
                codes_o.ramp_dn <= WGC_RST_CODE;
                codes_o.ramp_up <= WGC_RST_CODE;
                codes_o.amp     <= WGC_RST_CODE;
            end else begin
                codes_o.ramp_dn <= dn_act;
                codes_o.ramp_up <= up_act;
                codes_o.amp     <= amp_act;
            end
        end
    end

    // ****************************************************************
    // Run and halt sequencing
    // ****************************************************************
    // Only sine and triangle may drain; square has no clean end point.
    assign halt_ok = sync_halt_q && ((waveform_choice_o == WGC_WAVE_SINE) ||
                                     (waveform_choice_o == WGC_WAVE_TRI));

    // Stop state; the oscillator is held at its lowest point while idle.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= WGC_ST_IDLE;
        end else begin
            case (st_q)
                WGC_ST_IDLE: begin
                    if (enable_q && waveform_choice_o != WGC_WAVE_DC) begin
                        st_q <= WGC_ST_RUN;
                    end
                end
                WGC_ST_RUN: begin
                    if (!enable_q || waveform_choice_o == WGC_WAVE_DC) begin
                        st_q <= halt_ok ? WGC_ST_DRAIN : WGC_ST_IDLE;
                    end
                end
                WGC_ST_DRAIN: begin
                    if (enable_q) begin
                        st_q <= WGC_ST_RUN;
                    end else if (cycle_end_i || !halt_ok) begin
                        st_q <= WGC_ST_IDLE;
                    end
                end
                default: begin
                    st_q <= WGC_ST_IDLE;
                end
            endcase
        end
    end

    // Run and park gates follow the state one cycle later; DC drive follows enable and waveform.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wave_run_o <= 1'b0;
            park_low_o <= 1'b1;
            dc_drive_o <= 1'b0;
        end else begin
            wave_run_o <= (st_q != WGC_ST_IDLE);
            park_low_o <= (st_q == WGC_ST_IDLE);
            dc_drive_o <= enable_q && (waveform_choice_o == WGC_WAVE_DC);
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_bus_answer;
        (psel_i && penable_i && !pready_o) |=> pready_o ##1 !pready_o;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("Slave did not answer after one wait state.");

    property p_start;
        (st_q == WGC_ST_IDLE && enable_q && waveform_choice_o == WGC_WAVE_SINE)
            |=> ##1 (wave_run_o && !park_low_o);
    endproperty
    a_start: assert property (p_start)
        else $error("Enabled waveform did not start.");

    property p_stop_now;
        (st_q == WGC_ST_RUN && !enable_q && !sync_halt_q) |=> ##1 park_low_o;
    endproperty
    a_stop_now: assert property (p_stop_now)
        else $error("Immediate halt did not park the output.");

    property p_drain_hold;
        (st_q == WGC_ST_DRAIN && !enable_q && !cycle_end_i && halt_ok)
            |=> (st_q == WGC_ST_DRAIN);
    endproperty
    a_drain_hold: assert property (p_drain_hold)
        else $error("Drain left before the cycle ended.");

    // A switch to square while draining is legal; the drain must then end at once.
    property p_drain_shape;
        (st_q == WGC_ST_DRAIN && waveform_choice_o == WGC_WAVE_SQUARE)
            |=> (st_q != WGC_ST_DRAIN);
    endproperty
    a_drain_shape: assert property (p_drain_shape)
        else $error("Square wave entered synchronous drain.");

    property p_group_hold;
        (ld_off && group_update_flag_q && !strobe) |=> $stable(off_act);
    endproperty
    a_group_hold: assert property (p_group_hold)
        else $error("Grouped offset reached the converter early.");

    property p_direct;
        (ld_amp && !group_update_flag_q && waveform_choice_o != WGC_WAVE_DC)
            ##1 (waveform_choice_o != WGC_WAVE_DC) |=> (codes_o.amp == $past(wcode, 2));
    endproperty
    a_direct: assert property (p_direct)
        else $error("Direct amplitude write did not take effect.");

    property p_dc_quiet;
        (waveform_choice_o == WGC_WAVE_DC) |=> (codes_o.amp == 12'h000 &&
            codes_o.ramp_up == 12'h000 && codes_o.ramp_dn == 12'h000);
    endproperty
    a_dc_quiet: assert property (p_dc_quiet)
        else $error("DC mode passed ramp or amplitude codes.");

    property p_dc_gate;
        (!enable_q) |=> !dc_drive_o;
    endproperty
    a_dc_gate: assert property (p_dc_gate)
        else $error("DC level driven while disabled.");

    property p_first_only;
        (wr_cmda && !wr_cmdb && !strobe) |=> $stable(off_act) && $stable(amp_act);
    endproperty
    a_first_only: assert property (p_first_only)
        else $error("A first byte alone changed a code.");

    property p_range;
        range_code_o <= WGC_RANGE_MAX;
    endproperty
    a_range: assert property (p_range)
        else $error("Range code out of table.");

    c_haver: cover property (st_q == WGC_ST_DRAIN ##[1:20] st_q == WGC_ST_IDLE);
    c_strobe: cover property (strobe && |pend);
    c_full: cover property (codes_o.ramp_up == WGC_FULL_CODE && codes_o.ramp_dn == WGC_FULL_CODE);
    c_dc: cover property (dc_drive_o);

endmodule

// ==== dv/wgc_top_tb_top.sv ====
// Purpose : Self-checking bench for the waveform generator control block.
// Assumes : APB slave with one wait state; cycle_end_i driven by the bench.
// Notes   : Bus answers are taken at the rising edge; other outputs on the falling edge.

`timescale 1ns/100ps

module wgc_top_tb_top
    import wgc_pkg::*;
;
    // ****************************************************************
    // Stimulus and observed signals
    // ****************************************************************
    logic                  clk_i = 1'b0;
    logic                  rst_i = 1'b1;
    logic                  psel = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite = 1'b0;
    logic [WGC_ADDR_W-1:0] paddr = '0;
    logic [31:0]           pwdata = '0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  cycle_end = 1'b0;
    wgc_codes_t            codes;
    logic [2:0]            range_code;
    wgc_wave_t             wave;
    logic                  run;
    logic                  park;
    logic                  dc;
    logic [31:0]           rd;
    logic                  err;
    int                    mismatches = 0;
    int                    check_count = 0;

    // Free-running 125 MHz clock.
    always #4 clk_i = ~clk_i;

    wgc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .cycle_end_i(cycle_end), .codes_o(codes),
        .range_code_o(range_code), .waveform_choice_o(wave), .wave_run_o(run),
        .park_low_o(park), .dc_drive_o(dc));

    // Compares one value and counts the outcome.
    task automatic chk(input string name, input logic [48:0] seen, input logic [48:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Command byte writes and a pause long enough for the outputs to follow.
    task automatic cmd(input logic [7:0] b);
        apb(1'b1, WGC_ADDR_CMDA, {24'h0, b});
    endtask
    task automatic pair(input logic [7:0] a, input logic [7:0] b);
        cmd(a);
        apb(1'b1, WGC_ADDR_CMDB, {24'h0, b});
    endtask
    task automatic settle();
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    // Watchdog: the whole sequence needs well under a thousand cycles.
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        conclude();
    end

    // Main sequence.
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk("run", run, 1'b0);
        chk("park", park, 1'b1);
        cmd(8'h01);
        pair(8'hef, 8'hff);
        pair(8'hc9, 8'h99);
        settle();
        chk("ramp_dn", codes.ramp_dn, 12'hfff);
        chk("ramp_up", codes.ramp_up, 12'h999);
        cmd(8'h25);
        settle();
        chk("range", range_code, 3'h5);
        cmd(8'h26);
        cmd(8'h2a);
        pair(8'h8a, 8'hbc);
        settle();
        chk("range", range_code, 3'h2);
        chk("amp held", codes.amp, 12'h000);
        apb(1'b0, WGC_ADDR_STATUS, 32'h0);
        chk("status", rd[10:4], 7'h4a);
        apb(1'b1, WGC_ADDR_STROBE, 32'h0);
        settle();
        chk("amp", codes.amp, 12'habc);
        cmd(8'h20);
        pair(8'hb3, 8'h45);
        pair(8'h81, 8'h23);
        settle();
        chk("offset", {codes.offset_sign, codes.offset}, 13'h1345);
        chk("amp direct", codes.amp, 12'h123);
        chk("park off", park, 1'b1);
        cmd(8'h05);
        settle();
        chk("run sine", {wave, run, park}, 4'h6);
        cmd(8'h01);
        settle();
        chk("stop", {run, park}, 2'h1);
        cmd(8'h0e);
        cmd(8'h0a);
        settle();
        chk("drain tri", {wave, run}, 3'h5);
        @(posedge clk_i);
        cycle_end <= 1'b1;
        @(posedge clk_i);
        cycle_end <= 1'b0;
        settle();
        chk("drained", {run, park}, 2'h1);
        cmd(8'h0f);
        cmd(8'h0b);
        settle();
        chk("square stop", {wave, run, park}, 4'hd);
        cmd(8'h00);
        settle();
        chk("dc idle", {wave, dc}, 3'h0);
        cmd(8'h04);
        settle();
        chk("dc on", {dc, run}, 2'h2);
        chk("dc codes", codes, {36'h0, 12'h345, 1'b1});
        apb(1'b1, 12'h010, 32'h0);
        chk("unmapped", err, 1'b1);
        apb(1'b1, WGC_ADDR_STATUS, 32'h0);
        chk("ro status", err, 1'b1);
        apb(1'b0, WGC_ADDR_CMDA, 32'h0);
        chk("read cmda", {err, rd}, 33'h0);
        conclude();
    end

endmodule
